// >>> hw/fsp_cfg.svh
// constants of the flash status and protection block
// assumes inclusion by bare name from the design modules and the testbench files
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// instruction opcodes
`define FSP_CMD_WRITE_ENABLE 8'h06
`define FSP_CMD_WRITE_DISABLE 8'h04
`define FSP_CMD_STATUS_READ 8'h05
`define FSP_CMD_STATUS_WRITE 8'h01
`define FSP_CMD_BYTE_PROG 8'h02
`define FSP_CMD_AUTO_INC_PROG 8'had
`define FSP_CMD_ERASE_4K 8'h20
`define FSP_CMD_ERASE_32K 8'h52
`define FSP_CMD_ERASE_64K 8'hd8
`define FSP_CMD_CHIP_ERASE_A 8'h60
`define FSP_CMD_CHIP_ERASE_B 8'hc7
`define FSP_CMD_IDENT_PROG 8'ha5
`define FSP_CMD_IDENT_LOCK 8'h85

// protect level reset value and decoded lower bounds
`define FSP_LEVEL_RESET 3'h7
`define FSP_LEVEL_NONE 3'h0
`define FSP_LEVEL_1_16 3'h1
`define FSP_LEVEL_1_8 3'h2
`define FSP_LEVEL_1_4 3'h3
`define FSP_LEVEL_1_2 3'h4
`define FSP_BASE_1_16 20'hf0000
`define FSP_BASE_1_8 20'he0000
`define FSP_BASE_1_4 20'hc0000
`define FSP_BASE_1_2 20'h80000
`define FSP_BASE_ALL 20'h00000
`define FSP_ARRAY_END 21'h100000
`define FSP_WORD_STEP 21'h000002

// bytes following the opcode in each accepted frame
`define FSP_LEN_NONE 3'h0
`define FSP_LEN_STATUS_WR 3'h1
`define FSP_LEN_AUTO_NEXT 3'h2
`define FSP_LEN_IDENT_PROG 3'h2
`define FSP_LEN_ERASE 3'h3
`define FSP_LEN_BYTE_PROG 3'h4
`define FSP_LEN_AUTO_FIRST 3'h5
`define FSP_LEN_MAX 3'h7

// link framing
`define FSP_BIT_LAST 3'h7
`define FSP_BIT_FIRST 3'h0
`define FSP_IDX_OPCODE 3'h0
`define FSP_IDX_MAX 3'h7

// internal operation times in ns and their cycle counts
`define FSP_CLK_NS 5
`define FSP_PROG_NS 1000
`define FSP_ERASE_NS 2000
`define FSP_CHIP_NS 4000
`define FSP_IDENT_NS 1000
`define FSP_PROG_CYC ((`FSP_PROG_NS) / (`FSP_CLK_NS))
`define FSP_ERASE_CYC ((`FSP_ERASE_NS) / (`FSP_CLK_NS))
`define FSP_CHIP_CYC ((`FSP_CHIP_NS) / (`FSP_CLK_NS))
`define FSP_IDENT_CYC ((`FSP_IDENT_NS) / (`FSP_CLK_NS))

// security identifier layout; the factory value is arbitrary
`define FSP_IDENT_BYTES 32
`define FSP_IDENT_FACTORY_BYTES 8
`define FSP_IDENT_FACTORY 64'h0123456789abcdef
`define FSP_IDENT_BLANK 8'hff
`define FSP_IDENT_USER_LO 8'h08
`define FSP_IDENT_USER_HI 8'h1f

`endif

// >>> hw/fsp_pkg.sv
// types shared by the flash status and protection modules
// assumes fsp_cfg.svh on the include path
package fsp_pkg;

	// one byte received on the link and its position in the frame
	typedef struct packed {
		logic [7:0] data;
		logic [2:0] idx;
	} fsp_rx_byte_s;

	// field order gives bit 7 down to bit 0 of the status register
	typedef struct packed {
		logic lock;
		logic auto_inc;
		logic id_lock;
		logic [2:0] level;
		logic wr_en;
		logic busy;
	} fsp_status_s;

	typedef enum logic [2:0] {
		FSP_REQ_PROG,
		FSP_REQ_WORD,
		FSP_REQ_ERASE_4K,
		FSP_REQ_ERASE_32K,
		FSP_REQ_ERASE_64K,
		FSP_REQ_CHIP,
		FSP_REQ_IDENT_PROG,
		FSP_REQ_IDENT_LOCK
	} fsp_req_kind_e;

	typedef struct packed {
		logic valid;
		fsp_req_kind_e kind;
		logic [19:0] addr;
		logic [15:0] data;
	} fsp_array_req_s;

	typedef enum logic {
		FSP_READY,
		FSP_BUSY
	} fsp_state_e;

endpackage

// >>> hw/fsp_link.sv
// serial link front end on the host's serial clock
// assumes chip enable frames every instruction and the clock stands still outside frames
`timescale 1ns/100ps
`include "fsp_cfg.svh"
module fsp_link (
	input wire logic sck,
	input wire logic ce_n,
	input wire logic si,
	input wire logic srst,
	input wire fsp_pkg::fsp_status_s status_pub,
	output fsp_pkg::fsp_rx_byte_s rx_byte,
	output logic rx_toggle,
	output logic so,
	output logic so_oe_n
);
	import fsp_pkg::*;

	logic [2:0] bit_cnt;
	logic [2:0] byte_idx;
	logic [6:0] rx_shift;
	logic status_mode;
	logic [6:0] tx_shift;
	logic [7:0] pub_bits;

	assign pub_bits = status_pub;

	// counters restart whenever the host deselects
	always_ff @(posedge sck or posedge ce_n) begin
		if (ce_n) begin
			bit_cnt <= `FSP_BIT_FIRST;
			rx_shift <= 7'h00;
			byte_idx <= `FSP_IDX_OPCODE;
			status_mode <= 1'b0;
		end else begin
			bit_cnt <= bit_cnt + 3'h1;
			rx_shift <= {rx_shift[5:0], si};
			if (bit_cnt == `FSP_BIT_LAST) begin
				if (byte_idx != `FSP_IDX_MAX) begin
					byte_idx <= byte_idx + 3'h1;
				end
				if (byte_idx == `FSP_IDX_OPCODE && {rx_shift, si} == `FSP_CMD_STATUS_READ) begin
					status_mode <= 1'b1;
				end
			end
		end
	end

	// the toggle must survive deselect, so only srst clears it
	always_ff @(posedge sck or posedge srst) begin
		if (srst) begin
			rx_byte <= '0;
			rx_toggle <= 1'b0;
		end else if (!ce_n && bit_cnt == `FSP_BIT_LAST) begin
			rx_byte.data <= {rx_shift, si};
			rx_byte.idx <= byte_idx;
			rx_toggle <= !rx_toggle;
		end
	end

	// status byte repeats every eight clocks until deselect
	always_ff @(negedge sck or posedge ce_n) begin
		if (ce_n) begin
			so <= 1'b0;
			so_oe_n <= 1'b1;
			tx_shift <= 7'h00;
		end else if (status_mode && bit_cnt == `FSP_BIT_FIRST) begin
			so <= pub_bits[7];
			tx_shift <= pub_bits[6:0];
			so_oe_n <= 1'b0;
		end else begin
			so <= tx_shift[6];
			tx_shift <= {tx_shift[5:0], 1'b0};
		end
	end

endmodule

// >>> hw/fsp_status_protect.sv
// status register, block protection and security identifier of a serial flash
// assumes a host on the serial pins and an array controller that takes array_req
// Overview of operation
// - identifier holds 256 bits: 64 fixed factory bits, 192 user-programmable bits.
// - factory identifier bits never change; only reset returns the user bytes to blank.
// - identifier program writes only addresses inside the user segment.
// - lockout sets status bit 5, blocks identifier writes, flag never clears.
// - at power-up the lock flag shows whether a lockout ever completed.
// - while busy only status reads are accepted; host only polls.
// - status bit 0 is busy, read-only, zero at power-up.
// - status bit 1 is the write-enable latch; clear means writes ignored.
// - write-enable latch clears at power-up, on status write, and after each completed operation except non-final auto-increment words.
// - status bit 6 shows auto-increment mode; byte mode after power-up.
// - protect level bits 2 to 4 are writable, all ones at power-up.
// - protect level decodes to upper sixteenth, eighth, quarter, half, or all.
// - program or erase into the protected range is rejected.
// - status write changes protect level only if pin high or lock clear.
// - chip erase runs only with protect level zero.
// - bit 7 locks itself and level while the protect pin is low.
// - protect lock bit is zero after every power-up.
// - identifier program is a5 plus address and data; lockout is 85.
// - status read repeats the register each byte until deselect.
`timescale 1ns/100ps
`include "fsp_cfg.svh"
module fsp_status_protect (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic sck,
	input wire logic ce_n,
	input wire logic si,
	input wire logic wp_n,
	input wire logic id_lock_nv,
	output logic so,
	output logic so_oe_n,
	output fsp_pkg::fsp_status_s status_view,
	output fsp_pkg::fsp_array_req_s array_req,
	output logic [255:0] security_identifier
);
	import fsp_pkg::*;

	localparam logic [63:0] IDENT_FACTORY = `FSP_IDENT_FACTORY;
	localparam logic [15:0] PROG_CYC = 16'(`FSP_PROG_CYC);
	localparam logic [15:0] ERASE_CYC = 16'(`FSP_ERASE_CYC);
	localparam logic [15:0] CHIP_CYC = 16'(`FSP_CHIP_CYC);
	localparam logic [15:0] IDENT_CYC = 16'(`FSP_IDENT_CYC);

	fsp_rx_byte_s rx_byte;
	logic rx_toggle;
	logic tog_s1, tog_s2, tog_s3;
	logic ce_s1, ce_s2, ce_s3, ce_s4;
	logic wp_s1, wp_s2;
	logic rx_evt;
	logic frame_end;

	logic [7:0] fr_op;
	logic fr_op_seen;
	logic [39:0] fr_data;
	logic [2:0] fr_cnt;

	fsp_state_e state;
	logic [15:0] busy_cnt;
	fsp_req_kind_e busy_kind;
	logic busy_done;

	logic wr_en;
	logic [2:0] level;
	logic lock;
	logic id_lock;
	logic auto_inc;
	logic [19:0] auto_addr;
	fsp_status_s status_live;
	fsp_status_s wr_view;

	logic exec_start;
	fsp_req_kind_e exec_kind;
	logic [19:0] exec_addr;
	logic [15:0] exec_data;
	logic [15:0] exec_cycles;
	logic do_wr_en;
	logic do_wr_dis;
	logic do_status_wr;
	logic [20:0] next_auto_addr;
	logic [20:0] auto_limit;
	logic auto_hit;
	logic ident_wr;
	logic [7:0] ident_mem [0:`FSP_IDENT_BYTES-1];

	// lower bound of the protected range for a level
	function automatic logic [19:0] protect_base(input logic [2:0] lvl);
		logic [19:0] base;
		base = `FSP_BASE_ALL;
		case (lvl)
			`FSP_LEVEL_1_16: base = `FSP_BASE_1_16;
			`FSP_LEVEL_1_8: base = `FSP_BASE_1_8;
			`FSP_LEVEL_1_4: base = `FSP_BASE_1_4;
			`FSP_LEVEL_1_2: base = `FSP_BASE_1_2;
			default: base = `FSP_BASE_ALL;
		endcase
		return base;
	endfunction

	function automatic logic is_protected(input logic [2:0] lvl, input logic [19:0] a);
		return (lvl != `FSP_LEVEL_NONE) && (a >= protect_base(lvl));
	endfunction

	fsp_link u_link (
		.sck(sck),
		.ce_n(ce_n),
		.si(si),
		.srst(srst),
		.status_pub(status_view),
		.rx_byte(rx_byte),
		.rx_toggle(rx_toggle),
		.so(so),
		.so_oe_n(so_oe_n)
	);

	// crossings: byte toggle, chip enable level and protect pin
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
			ce_s1 <= 1'b1;
			ce_s2 <= 1'b1;
			ce_s3 <= 1'b1;
			ce_s4 <= 1'b1;
			wp_s1 <= 1'b1;
			wp_s2 <= 1'b1;
		end else begin
			tog_s1 <= rx_toggle;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
			ce_s1 <= ce_n;
			ce_s2 <= ce_s1;
			ce_s3 <= ce_s2;
			ce_s4 <= ce_s3;
			wp_s1 <= wp_n;
			wp_s2 <= wp_s1;
		end
	end

	assign rx_evt = tog_s2 ^ tog_s3;
	// one cycle later than the toggle path so the last byte lands first
	assign frame_end = ce_s3 && !ce_s4;

	// gather the opcode and the bytes that follow it
	always_ff @(posedge sys_clk) begin
		if (srst || frame_end) begin
			fr_op_seen <= 1'b0;
			fr_cnt <= `FSP_LEN_NONE;
		end else if (rx_evt) begin
			if (rx_byte.idx == `FSP_IDX_OPCODE) begin
				fr_op <= rx_byte.data;
				fr_op_seen <= 1'b1;
			end else begin
				fr_data <= {fr_data[31:0], rx_byte.data};
				if (fr_cnt != `FSP_LEN_MAX) begin
					fr_cnt <= fr_cnt + 3'h1;
				end
			end
		end
	end

	assign wr_view = fsp_status_s'(fr_data[7:0]);

	// instruction decode at the end of a frame
	always_comb begin
		exec_start = 1'b0;
		exec_kind = FSP_REQ_PROG;
		exec_addr = fr_data[27:8];
		exec_data = {8'h00, fr_data[7:0]};
		exec_cycles = PROG_CYC;
		do_wr_en = 1'b0;
		do_wr_dis = 1'b0;
		do_status_wr = 1'b0;
		if (frame_end && fr_op_seen && state == FSP_READY) begin
			case (fr_op)
				`FSP_CMD_WRITE_ENABLE: begin
					do_wr_en = (fr_cnt == `FSP_LEN_NONE) && !auto_inc;
				end
				`FSP_CMD_WRITE_DISABLE: begin
					do_wr_dis = (fr_cnt == `FSP_LEN_NONE);
				end
				`FSP_CMD_STATUS_WRITE: begin
					do_status_wr = (fr_cnt == `FSP_LEN_STATUS_WR) && wr_en && !auto_inc;
				end
				`FSP_CMD_BYTE_PROG: begin
					exec_start = (fr_cnt == `FSP_LEN_BYTE_PROG) && wr_en && !auto_inc
						&& !is_protected(level, fr_data[27:8]);
				end
				`FSP_CMD_AUTO_INC_PROG: begin
					exec_kind = FSP_REQ_WORD;
					exec_data = fr_data[15:0];
					if (auto_inc) begin
						exec_addr = auto_addr;
						exec_start = (fr_cnt == `FSP_LEN_AUTO_NEXT) && !is_protected(level, auto_addr);
					end else begin
						exec_addr = {fr_data[35:17], 1'b0};
						exec_start = (fr_cnt == `FSP_LEN_AUTO_FIRST) && wr_en
							&& !is_protected(level, {fr_data[35:17], 1'b0});
					end
				end
				`FSP_CMD_ERASE_4K, `FSP_CMD_ERASE_32K, `FSP_CMD_ERASE_64K: begin
					exec_addr = fr_data[19:0];
					exec_cycles = ERASE_CYC;
					if (fr_op == `FSP_CMD_ERASE_4K) begin
						exec_kind = FSP_REQ_ERASE_4K;
					end else if (fr_op == `FSP_CMD_ERASE_32K) begin
						exec_kind = FSP_REQ_ERASE_32K;
					end else begin
						exec_kind = FSP_REQ_ERASE_64K;
					end
					exec_start = (fr_cnt == `FSP_LEN_ERASE) && wr_en && !auto_inc
						&& !is_protected(level, fr_data[19:0]);
				end
				`FSP_CMD_CHIP_ERASE_A, `FSP_CMD_CHIP_ERASE_B: begin
					exec_kind = FSP_REQ_CHIP;
					exec_addr = `FSP_BASE_ALL;
					exec_cycles = CHIP_CYC;
					exec_start = (fr_cnt == `FSP_LEN_NONE) && wr_en && !auto_inc
						&& level == `FSP_LEVEL_NONE;
				end
				`FSP_CMD_IDENT_PROG: begin
					exec_kind = FSP_REQ_IDENT_PROG;
					exec_addr = {12'h000, fr_data[15:8]};
					exec_cycles = IDENT_CYC;
					exec_start = (fr_cnt == `FSP_LEN_IDENT_PROG) && wr_en && !auto_inc
						&& !id_lock
						&& fr_data[15:8] >= `FSP_IDENT_USER_LO
						&& fr_data[15:8] <= `FSP_IDENT_USER_HI;
				end
				`FSP_CMD_IDENT_LOCK: begin
					exec_kind = FSP_REQ_IDENT_LOCK;
					exec_addr = `FSP_BASE_ALL;
					exec_data = 16'h0000;
					exec_cycles = IDENT_CYC;
					exec_start = (fr_cnt == `FSP_LEN_NONE) && wr_en && !auto_inc;
				end
				default: begin
					exec_start = 1'b0;
				end
			endcase
		end
	end

	assign ident_wr = exec_start && exec_kind == FSP_REQ_IDENT_PROG;

	// internal operation timer drives the busy bit
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state <= FSP_READY;
			busy_cnt <= 16'h0000;
			busy_kind <= FSP_REQ_PROG;
		end else begin
			unique case (state)
				FSP_READY: begin
					if (exec_start) begin
						state <= FSP_BUSY;
						busy_cnt <= exec_cycles - 16'h0001;
						busy_kind <= exec_kind;
					end
				end
				FSP_BUSY: begin
					if (busy_cnt == 16'h0000) begin
						state <= FSP_READY;
					end else begin
						busy_cnt <= busy_cnt - 16'h0001;
					end
				end
			endcase
		end
	end

	assign busy_done = (state == FSP_BUSY) && (busy_cnt == 16'h0000);

	// word mode ends at the top of the unprotected area
	assign next_auto_addr = {1'b0, auto_addr} + `FSP_WORD_STEP;
	assign auto_limit = (level == `FSP_LEVEL_NONE) ? `FSP_ARRAY_END : {1'b0, protect_base(level)};
	assign auto_hit = next_auto_addr >= auto_limit;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			auto_inc <= 1'b0;
			auto_addr <= `FSP_BASE_ALL;
		end else if (do_wr_dis) begin
			auto_inc <= 1'b0;
		end else if (exec_start && exec_kind == FSP_REQ_WORD) begin
			auto_inc <= 1'b1;
			auto_addr <= exec_addr;
		end else if (busy_done && busy_kind == FSP_REQ_WORD) begin
			auto_addr <= next_auto_addr[19:0];
			if (auto_hit) begin
				auto_inc <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_en <= 1'b0;
		end else if (do_wr_en) begin
			wr_en <= 1'b1;
		end else if (do_wr_dis || do_status_wr) begin
			wr_en <= 1'b0;
		end else if (busy_done && !(busy_kind == FSP_REQ_WORD && !auto_hit)) begin
			wr_en <= 1'b0;
		end
	end

	// status write loads only the level and lock bits from its data byte
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			level <= `FSP_LEVEL_RESET;
			lock <= 1'b0;
		end else if (do_status_wr && (wp_s2 || !lock)) begin
			level <= wr_view.level;
			lock <= wr_view.lock;
		end
	end

	// lock flag reloads from its stored copy and never clears afterwards
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			id_lock <= id_lock_nv;
		end else if (busy_done && busy_kind == FSP_REQ_IDENT_LOCK) begin
			id_lock <= 1'b1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `FSP_IDENT_BYTES; g++) begin : g_ident
			if (g < `FSP_IDENT_FACTORY_BYTES) begin : g_fixed
				always_ff @(posedge sys_clk) begin
					ident_mem[g] <= IDENT_FACTORY[g*8 +: 8];
				end
			end else begin : g_user
				// programming only clears bits; only srst sets them back to blank
				always_ff @(posedge sys_clk) begin
					if (srst) begin
						ident_mem[g] <= `FSP_IDENT_BLANK;
					end else if (ident_wr && exec_addr[4:0] == 5'(g)) begin
						ident_mem[g] <= ident_mem[g] & exec_data[7:0];
					end
				end
			end
			assign security_identifier[g*8 +: 8] = ident_mem[g];
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			array_req <= '0;
		end else begin
			array_req.valid <= exec_start;
			if (exec_start) begin
				array_req.kind <= exec_kind;
				array_req.addr <= exec_addr;
				array_req.data <= exec_data;
			end
		end
	end

	assign status_live = '{lock: lock, auto_inc: auto_inc, id_lock: id_lock, level: level,
		wr_en: wr_en, busy: state == FSP_BUSY};

	// refreshed right after each byte so the link loads a settled copy
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			status_view <= '{lock: 1'b0, auto_inc: 1'b0, id_lock: 1'b0,
				level: `FSP_LEVEL_RESET, wr_en: 1'b0, busy: 1'b0};
		end else if (rx_evt || ce_s2) begin
			status_view <= status_live;
		end
	end

endmodule

// >>> testbench/fsp_sp_assertions.sv
// concurrent checks on the ports of the status and protection block
// assumes a bind onto fsp_status_protect, one core clock domain
`timescale 1ns/100ps
`include "fsp_cfg.svh"
module fsp_sp_assertions (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic wp_n,
	input wire logic id_lock_nv,
	input wire logic ce_n,
	input wire logic so,
	input wire logic so_oe_n,
	input wire fsp_pkg::fsp_status_s status_view,
	input wire fsp_pkg::fsp_array_req_s array_req,
	input wire logic [255:0] security_identifier
);
	import fsp_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// address inside the range that the level protects
	function automatic logic hit(input logic [2:0] lv, input logic [19:0] a);
		case (lv)
			3'h0: hit = 1'b0;
			3'h1: hit = a >= 20'hf0000;
			3'h2: hit = a >= 20'he0000;
			3'h3: hit = a >= 20'hc0000;
			3'h4: hit = a >= 20'h80000;
			default: hit = 1'b1;
		endcase
	endfunction
	wire logic arr_op = array_req.valid && array_req.kind < FSP_REQ_CHIP;
	a_reset_status: assert property (disable iff (1'b0) srst |=> status_view == 8'h1c)
		else $error("status wrong during or just after reset");
	a_lock_restore: assert property (disable iff (1'b0)
		$fell(srst) |-> ##[1:3] status_view.id_lock == id_lock_nv)
		else $error("identifier lock flag not restored");
	a_lock_sticky: assert property (status_view.id_lock |=> status_view.id_lock)
		else $error("identifier lock flag cleared");
	a_ident_frozen: assert property (status_view.id_lock |=> $stable(security_identifier))
		else $error("identifier changed after lockout");
	a_factory_fixed: assert property (security_identifier[63:0] == `FSP_IDENT_FACTORY)
		else $error("factory identifier bits changed");
	a_pin_lock: assert property ((!wp_n [*4] ##0 status_view.lock)
		|=> $stable({status_view.lock, status_view.level}))
		else $error("locked protect bits changed");
	a_chip_zero: assert property (array_req.valid && array_req.kind == FSP_REQ_CHIP
		|-> status_view.level == 3'h0)
		else $error("chip erase with protect level set");
	a_prot_range: assert property (arr_op |-> !hit(status_view.level, array_req.addr))
		else $error("array operation inside protected range");
	a_req_wen: assert property (array_req.valid |-> status_view.wr_en)
		else $error("array operation without write enable");
	a_busy_hold: assert property (array_req.valid |=> status_view.busy [*8])
		else $error("busy not raised for array operation");
	a_wel_done: assert property ($fell(status_view.busy) && !status_view.auto_inc
		|-> !status_view.wr_en)
		else $error("write enable left set after operation");
	a_idle_quiet: assert property (ce_n [*3] |-> so_oe_n && !so)
		else $error("serial output driven while deselected");
	c_prog: cover property (array_req.valid && array_req.kind == FSP_REQ_PROG);
	c_chip: cover property (array_req.valid && array_req.kind == FSP_REQ_CHIP);
	c_locked: cover property (status_view.id_lock);
endmodule

bind fsp_status_protect fsp_sp_assertions fsp_sp_assertions_i (.sys_clk, .srst, .wp_n,
	.id_lock_nv, .ce_n, .so, .so_oe_n, .status_view, .array_req, .security_identifier);

// >>> testbench/fsp_host.sv
// serial host model: frames instructions on the link pins
// assumes callers leave reset done before the first frame
`timescale 1ns/100ps
module fsp_host (
	output logic sck,
	output logic ce_n,
	output logic si,
	input wire logic so
);
	// a rising chip enable clears the link counters before the first frame
	initial begin
		sck = 1'b0;
		ce_n = 1'b0;
		si = 1'b0;
		#1 ce_n = 1'b1;
	end
	// n bytes of d, right aligned, msb first; r keeps the last 16 bits seen
	task automatic xfer(input int n, input logic [47:0] d, output logic [15:0] r);
		r = 16'h0;
		ce_n = 1'b0;
		for (int i = 8 * n - 1; i >= 0; i--) begin
			si = d[i];
			#32 sck = 1'b1;
			r = {r[14:0], so};
			#32 sck = 1'b0;
		end
		#32 ce_n = 1'b1;
		// released line shows the inverse of its last bit
		si = ~si;
		#64;
	endtask
endmodule

// >>> testbench/test_flash_status_and_protection.sv
// self-checking bench of the flash status and protection block
// assumes the host model on the link pins and the bound checker
`timescale 1ns/100ps
`include "fsp_cfg.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
	$display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module test_flash_status_and_protection;
	import fsp_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b0;
	logic wp_n = 1'b1;
	logic id_lock_nv = 1'b0;
	logic sck, ce_n, si, so, so_oe_n;
	fsp_status_s status_view;
	fsp_array_req_s array_req, last_req;
	logic [255:0] security_identifier;
	logic [15:0] r;
	int failures = 0;
	int n_compared = 0;
	int n_req = 0;
	always #2.5 sys_clk = ~sys_clk;
	fsp_status_protect fsp_status_protect_i (.sys_clk, .srst, .sck, .ce_n, .si, .wp_n,
		.id_lock_nv, .so, .so_oe_n, .status_view, .array_req, .security_identifier);
	fsp_host fsp_host_i (.sck, .ce_n, .si, .so);
	always @(posedge sys_clk) begin
		if (array_req.valid) begin
			n_req++;
			last_req = array_req;
		end
	end
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic do_reset();
		@(posedge sys_clk);
		#1 srst = 1'b1;
		repeat (12) @(posedge sys_clk);
		#1 srst = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1;
	endtask
	task automatic cmd(input int n, input logic [47:0] d);
		fsp_host_i.xfer(n, d, r);
	endtask
	task automatic wen();
		cmd(1, 8'h06);
	endtask
	task automatic rd(output logic [7:0] s);
		fsp_host_i.xfer(3, {8'h05, 16'h0}, r);
		s = r[15:8];
	endtask
	task automatic poll(output logic [7:0] s);
		for (int i = 0; i < 40; i++) begin
			rd(s);
			if (s[0] === 1'b0) return;
		end
		failures++;
		$display("MISMATCH busy wait expected 0 seen 1");
		finish_test();
	endtask
	task automatic t_reset();
		logic [7:0] s;
		rd(s);
		`CHK("reset status", 8'h1c, s)
		`CHK("repeated status", 8'h1c, r[7:0])
		`CHK("factory id", `FSP_IDENT_FACTORY, security_identifier[63:0])
		wen();
		cmd(2, {8'h01, 8'he3});
		rd(s);
		`CHK("status write", 8'h80, s)
		wen();
		cmd(2, {8'h01, 8'h04});
		rd(s);
		`CHK("pin high write", 8'h04, s)
		wen();
		cmd(1, 8'h04);
		rd(s);
		`CHK("write disable", 8'h04, s)
		$display("test reset done");
	endtask
	task automatic t_levels();
		logic [19:0] base [5] = '{20'hf0000, 20'he0000, 20'hc0000, 20'h80000, 20'h00000};
		logic [7:0] op [3] = '{8'h20, 8'h52, 8'hd8};
		logic [7:0] s;
		int n0;
		for (int lv = 1; lv <= 5; lv++) begin
			wen();
			cmd(2, {8'h01, 3'h0, lv[2:0], 2'h0});
			wen();
			n0 = n_req;
			cmd(4, {op[lv % 3], 4'h0, base[lv - 1]});
			`CHK("protected erase", n0, n_req)
			if (lv < 5) begin
				cmd(4, {op[lv % 3], 4'h0, base[lv - 1] - 20'h1});
				`CHK("open erase", n0 + 1, n_req)
				poll(s);
				`CHK("after erase", {3'h0, lv[2:0], 2'h0}, s)
			end
		end
		$display("test levels done");
	endtask
	task automatic t_busy();
		logic [7:0] s;
		wen();
		cmd(2, {8'h01, 8'h00});
		wen();
		cmd(5, {8'h02, 24'h000100, 8'h3c});
		`CHK("prog kind", FSP_REQ_PROG, last_req.kind)
		`CHK("prog addr", 20'h00100, last_req.addr)
		`CHK("prog data", 16'h003c, last_req.data)
		rd(s);
		`CHK("busy set", 1'b1, s[0])
		poll(s);
		`CHK("after prog", 8'h00, s)
		$display("test busy done");
	endtask
	task automatic t_chip();
		logic [7:0] s;
		int n0;
		wen();
		cmd(2, {8'h01, 8'h04});
		wen();
		n0 = n_req;
		cmd(1, 8'h60);
		`CHK("chip refused", n0, n_req)
		wen();
		cmd(2, {8'h01, 8'h00});
		wen();
		cmd(1, 8'hc7);
		`CHK("chip kind", FSP_REQ_CHIP, last_req.kind)
		// a complete erase frame that ends while the chip erase still runs
		n0 = n_req;
		cmd(4, {8'h20, 24'h001000});
		`CHK("dropped while busy", n0, n_req)
		poll(s);
		`CHK("after chip", 8'h00, s)
		$display("test chip done");
	endtask
	task automatic t_pin();
		logic [7:0] s;
		wen();
		cmd(2, {8'h01, 8'h84});
		@(posedge sys_clk);
		#1 wp_n = 1'b0;
		wen();
		cmd(2, {8'h01, 8'h00});
		rd(s);
		`CHK("locked write", 8'h84, s)
		@(posedge sys_clk);
		#1 wp_n = 1'b1;
		wen();
		cmd(2, {8'h01, 8'h00});
		rd(s);
		`CHK("unlocked write", 8'h00, s)
		$display("test pin done");
	endtask
	task automatic t_auto();
		logic [7:0] s;
		wen();
		cmd(6, {8'had, 24'h0ffffc, 16'h1234});
		`CHK("word kind", FSP_REQ_WORD, last_req.kind)
		`CHK("word addr", 20'hffffc, last_req.addr)
		`CHK("word data", 16'h1234, last_req.data)
		poll(s);
		`CHK("word mode", 8'h42, s)
		cmd(3, {8'had, 16'h5678});
		`CHK("word next", 20'hffffe, last_req.addr)
		poll(s);
		`CHK("word end", 8'h00, s)
		$display("test auto done");
	endtask
	task automatic t_ident();
		logic [7:0] s;
		wen();
		cmd(3, {8'ha5, 8'h08, 8'h5a});
		poll(s);
		`CHK("user id byte", 8'h5a, security_identifier[71:64])
		wen();
		cmd(3, {8'ha5, 8'h03, 8'h00});
		rd(s);
		`CHK("factory kept", `FSP_IDENT_FACTORY, security_identifier[63:0])
		wen();
		cmd(1, 8'h85);
		poll(s);
		`CHK("after lockout", 8'h20, s)
		wen();
		cmd(3, {8'ha5, 8'h09, 8'h00});
		rd(s);
		`CHK("locked id byte", 8'hff, security_identifier[79:72])
		id_lock_nv = 1'b1;
		do_reset();
		rd(s);
		`CHK("lock at power-up", 8'h3c, s)
		$display("test ident done");
	endtask
	initial begin
		// a rising reset clears the link's byte toggle before the first edge
		#1 srst = 1'b1;
		do_reset();
		t_reset();
		t_levels();
		t_busy();
		t_chip();
		t_pin();
		t_auto();
		t_ident();
		finish_test();
	end
endmodule
